// *** design/bfd_distribute.sv ***
// bit field distribute datapath with an avalon-mm register slave
// assumes one clock, synchronous reset, and a master that holds each request until waitrequest is low
//
// How it works
// RL1: on execution the field of the given length starting at the source bit is written at the destination bit.
// RL2: software keeps the source bit position inside the source operand width.
// RL3: software keeps the destination bit position inside the destination operand width.
// RL4: software keeps the field length between one and thirty-two bits.
// RL5: field bits above the destination top bit are dropped and never wrap.
// RL6: narrower byte or halfword operands are zero-extended to 32 bits before the transfer.
// RL7: the source word is only read, never written, by an execution.
// RL8: gated insert drives step out low in prescan, postscan or with step in low, and transfers nothing.
// RL9: gated insert with step in high transfers the field into the destination and drives step out high.
// RL10: gated insert leaves the zero and sign flags alone.
// RL11: targeted insert starts from the whole target word and overwrites only the field bits.
// RL12: targeted insert leaves both target and source untouched.
// RL13: targeted insert with enable input low clears enable output and holds the previous result.
// RL14: targeted insert with enable input high executes and sets enable output.
// RL15: enable input resets high, and the text form treats it as always high.
// RL16: targeted insert updates the flags from the 32-bit result on every execution.
// RL17: the flags are zero and sign, registered in the same cycle as the result.
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`include "bfd_params.svh"
`default_nettype none

module bfd_distribute (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [3:0] avs_address, // word address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // write byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall, low for one cycle per answer
  output logic step_out, // gated insert step condition out
  output logic enable_output, // targeted insert valid result
  output logic [31:0] result_word, // targeted insert result
  output logic [31:0] destination_word, // gated insert destination
  output logic flag_zero, // result is zero
  output logic flag_sign // result bit 31
);

  // ==========================================================
  // request bundle and decode
  bfd_pkg::bfd_avreq_s req;
  wire logic [5:0] byte_addr;
  wire logic accept;
  wire logic wr_accept;
  wire logic [31:0] be_mask;
  wire logic sel_ctrl;
  wire logic sel_source;
  wire logic sel_field;
  wire logic sel_target;
  wire logic sel_dest;
  wire logic sel_result;
  wire logic sel_status;
  wire logic sel_exec;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata, byteenable: avs_byteenable};
  assign byte_addr = {req.address, 2'b00};
  // the transfer completes at the edge where the master sees waitrequest low
  assign accept = (req.read | req.write) & ~avs_waitrequest;
  assign wr_accept = accept & req.write;
  assign be_mask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                    {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
  assign sel_ctrl = (byte_addr == `BFD_OFS_CTRL);
  assign sel_source = (byte_addr == `BFD_OFS_SOURCE);
  assign sel_field = (byte_addr == `BFD_OFS_FIELD);
  assign sel_target = (byte_addr == `BFD_OFS_TARGET);
  assign sel_dest = (byte_addr == `BFD_OFS_DEST);
  assign sel_result = (byte_addr == `BFD_OFS_RESULT);
  assign sel_status = (byte_addr == `BFD_OFS_STATUS);
  assign sel_exec = (byte_addr == `BFD_OFS_EXEC);

  // write strobes, one per register, each live only in the answer cycle
  wire logic wr_ctrl;
  wire logic wr_field;
  wire logic wr_source;
  wire logic wr_target;
  wire logic wr_dest;
  wire logic wr_go;

  assign wr_ctrl = wr_accept & sel_ctrl;
  assign wr_field = wr_accept & sel_field;
  assign wr_source = wr_accept & sel_source;
  assign wr_target = wr_accept & sel_target;
  assign wr_dest = wr_accept & sel_dest;
  assign wr_go = wr_accept & sel_exec & req.byteenable[0] & req.writedata[`BFD_EXEC_GO_BIT];

  // ==========================================================
  // software registers
  // map, byte offsets: 0x00 control, 0x04 source, 0x08 field, 0x0c target, 0x10 destination,
  // 0x14 result (read only), 0x18 status (read only), 0x1c go (write only, reads zero)
  // control: [0] targeted, [1] step in, [2] prescan, [3] postscan, [4] enable input,
  // [5] text form, [7:6] source width, [9:8] destination width (0 byte, 1 half, 2 or 3 word)
  // field: [4:0] source bit, [12:8] destination bit, [21:16] length
  // status: [0] step out, [1] enable output, [2] zero, [3] sign
  // positions and lengths are not range-checked: keeping them legal is the caller's duty
  // a zero length inserts no field bits yet still counts as a scan
  bfd_pkg::bfd_ctrl_s ctrl;
  bfd_pkg::bfd_field_s field_cfg;
  logic [31:0] source_word;
  logic [31:0] target_word;
  logic exec_pending;

  wire logic [31:0] next_ctrl_bits;
  wire logic [31:0] next_field_bits;
  wire logic [31:0] next_source;
  wire logic [31:0] next_target;
  wire logic [31:0] dest_sw;

  assign next_ctrl_bits = ((ctrl & ~be_mask) | (req.writedata & be_mask)) & `BFD_CTRL_WMASK;
  assign next_field_bits = ((field_cfg & ~be_mask) | (req.writedata & be_mask)) & `BFD_FIELD_WMASK;
  assign next_source = (source_word & ~be_mask) | (req.writedata & be_mask);
  assign next_target = (target_word & ~be_mask) | (req.writedata & be_mask);
  assign dest_sw = (destination_word & ~be_mask) | (req.writedata & be_mask);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= bfd_pkg::bfd_ctrl_s'(`BFD_CTRL_RESET); // RL15
    end else if (wr_ctrl) begin
      ctrl <= bfd_pkg::bfd_ctrl_s'(next_ctrl_bits);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      field_cfg <= bfd_pkg::bfd_field_s'(`BFD_FIELD_RESET);
    end else if (wr_field) begin
      field_cfg <= bfd_pkg::bfd_field_s'(next_field_bits);
    end
  end

  // only the bus may change source and target; execution never writes them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      source_word <= `BFD_WORD_RESET;
    end else if (wr_source) begin
      source_word <= next_source; // RL7 RL12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      target_word <= `BFD_WORD_RESET;
    end else if (wr_target) begin
      target_word <= next_target; // RL12
    end
  end

  // one scan per write of the go bit; runs the cycle after the write lands
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      exec_pending <= 1'b0;
    end else begin
      exec_pending <= wr_go;
    end
  end

  // ==========================================================
  // field insert datapath
  wire logic [31:0] gated_value;
  wire logic [31:0] targeted_value;

  bfd_field_insert #(
    .W(32)
  ) u_gated (
    .src_word(source_word),
    .base_word(destination_word),
    .src_pos(field_cfg.source_bit_position),
    .dst_pos(field_cfg.destination_bit_position),
    .len(field_cfg.length),
    .src_width(ctrl.src_width),
    .dst_width(ctrl.dst_width),
    .result(gated_value)
  );

  // targeted form works on whole 32-bit words for target and result
  bfd_field_insert #(
    .W(32)
  ) u_targeted (
    .src_word(source_word),
    .base_word(target_word), // RL11
    .src_pos(field_cfg.source_bit_position),
    .dst_pos(field_cfg.destination_bit_position),
    .len(field_cfg.length),
    .src_width(ctrl.src_width),
    .dst_width(bfd_pkg::BFD_WORD32),
    .result(targeted_value)
  );

  // ==========================================================
  // execution decisions
  wire logic gated_run;
  wire logic gated_block;
  wire logic targeted_enabled;
  wire logic targeted_run;
  wire logic targeted_skip;

  assign gated_block = ctrl.prescan | ctrl.postscan | ~ctrl.step_in; // RL8
  assign gated_run = exec_pending & ~ctrl.targeted & ~gated_block; // RL9
  // text form ignores the enable input entirely
  assign targeted_enabled = ctrl.text_form | ctrl.enable_input; // RL15
  assign targeted_run = exec_pending & ctrl.targeted & targeted_enabled; // RL14
  assign targeted_skip = exec_pending & ctrl.targeted & ~targeted_enabled; // RL13

  // gated destination: written by the transfer or by software; transfer wins on a clash
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      destination_word <= `BFD_WORD_RESET;
    end else if (gated_run) begin
      destination_word <= gated_value; // RL9 RL1
    end else if (wr_dest) begin
      destination_word <= dest_sw;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      step_out <= 1'b0;
    end else if (exec_pending & ~ctrl.targeted) begin
      step_out <= ~gated_block; // RL8 RL9
    end
  end

  // zero and sign follow the new result word at the same edge
  wire logic next_flag_zero;
  wire logic next_flag_sign;

  assign next_flag_zero = (targeted_value == 32'h0000_0000); // RL17
  assign next_flag_sign = targeted_value[31]; // RL17

  // result, enable and flags move only on targeted scans; gated runs never reach them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_word <= `BFD_WORD_RESET;
    end else if (targeted_run) begin
      result_word <= targeted_value; // RL11 RL14
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable_output <= 1'b0;
    end else if (targeted_run) begin
      enable_output <= 1'b1; // RL14
    end else if (targeted_skip) begin
      enable_output <= 1'b0; // RL13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_zero <= 1'b0;
      flag_sign <= 1'b0;
    end else if (targeted_run) begin
      flag_zero <= next_flag_zero; // RL16 RL17
      flag_sign <= next_flag_sign; // RL16 RL17 RL10
    end
  end

  // ==========================================================
  // read path and wait handshake
  wire logic [31:0] status_word;
  wire logic [31:0] read_word;
  wire logic next_waitrequest;
  wire logic read_take;

  assign status_word = (32'(step_out) << `BFD_STAT_STEP_BIT) |
                       (32'(enable_output) << `BFD_STAT_EN_BIT) |
                       (32'(flag_zero) << `BFD_STAT_ZERO_BIT) |
                       (32'(flag_sign) << `BFD_STAT_SIGN_BIT);
  // unmapped and write-only addresses read as zero
  assign read_word = sel_ctrl ? 32'(ctrl) :
                     sel_source ? source_word :
                     sel_field ? 32'(field_cfg) :
                     sel_target ? target_word :
                     sel_dest ? destination_word :
                     sel_result ? result_word :
                     sel_status ? status_word : 32'h0000_0000;
  // one wait cycle per request keeps read data registered and the timing fixed
  assign next_waitrequest = ~((req.read | req.write) & avs_waitrequest);
  // read data are caught at the taking edge and stand until the next read is taken
  assign read_take = req.read & avs_waitrequest;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= next_waitrequest;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (read_take) begin
      avs_readdata <= read_word;
    end
  end

endmodule : bfd_distribute

`default_nettype wire

// *** design/bfd_field_insert.sv ***
// combinational field extract and insert
// assumes positions and length already held stable by the caller
`default_nettype none

module bfd_field_insert #(
  parameter int W = 32
) (
  input wire logic [W-1:0] src_word, // source operand, never modified
  input wire logic [W-1:0] base_word, // word the field lands in
  input wire logic [4:0] src_pos, // lowest source bit of field
  input wire logic [4:0] dst_pos, // lowest destination bit of field
  input wire logic [5:0] len, // field length in bits
  input wire bfd_pkg::bfd_width_e src_width, // source operand width
  input wire bfd_pkg::bfd_width_e dst_width, // destination operand width
  output logic [W-1:0] result // base with field inserted
);

  // ==========================================================
  // elaboration check
  if (W != 32) begin : g_bad_width
    $error("bfd_field_insert serves only a 32-bit word");
  end

  // ==========================================================
  // widths and masks
  wire logic [31:0] src_mask;
  wire logic [31:0] dst_mask;
  wire logic [63:0] len_mask;
  wire logic [63:0] field;
  wire logic [63:0] placed;
  wire logic [63:0] placed_mask;
  wire logic [31:0] keep;

  assign src_mask = (src_width == bfd_pkg::BFD_WORD8) ? 32'h0000_00ff :
                    (src_width == bfd_pkg::BFD_WORD16) ? 32'h0000_ffff : 32'hffff_ffff; // RL6
  assign dst_mask = (dst_width == bfd_pkg::BFD_WORD8) ? 32'h0000_00ff :
                    (dst_width == bfd_pkg::BFD_WORD16) ? 32'h0000_ffff : 32'hffff_ffff; // RL6
  assign len_mask = (64'h1 << len) - 64'h1;
  assign field = ({32'h0, src_word & src_mask} >> src_pos) & len_mask; // RL1
  // 64-bit staging so bits pushed past the top fall away instead of wrapping
  assign placed = field << dst_pos; // RL1
  assign placed_mask = len_mask << dst_pos;
  assign keep = placed_mask[31:0] & dst_mask; // RL5
  assign result = (base_word & dst_mask & ~keep) | (placed[31:0] & keep); // RL1 RL11

endmodule : bfd_field_insert

`default_nettype wire

// *** design/bfd_params.svh ***
// bit field distribute: register offsets, field positions and reset values
// assumes inclusion by the package and the design modules only
`ifndef BFD_PARAMS_SVH
`define BFD_PARAMS_SVH

// ==========================================================
// register byte offsets
`define BFD_OFS_CTRL 6'h00
`define BFD_OFS_SOURCE 6'h04
`define BFD_OFS_FIELD 6'h08
`define BFD_OFS_TARGET 6'h0c
`define BFD_OFS_DEST 6'h10
`define BFD_OFS_RESULT 6'h14
`define BFD_OFS_STATUS 6'h18
`define BFD_OFS_EXEC 6'h1c

// ==========================================================
// field positions
`define BFD_EXEC_GO_BIT 0
`define BFD_STAT_STEP_BIT 0
`define BFD_STAT_EN_BIT 1
`define BFD_STAT_ZERO_BIT 2
`define BFD_STAT_SIGN_BIT 3

// ==========================================================
// reset values and writable masks
`define BFD_CTRL_RESET 32'h0000_0290
`define BFD_CTRL_WMASK 32'h0000_03ff
`define BFD_FIELD_RESET 32'h0001_0000
`define BFD_FIELD_WMASK 32'h003f_1f1f
`define BFD_WORD_RESET 32'h0000_0000

`endif

// *** design/bfd_pkg.sv ***
// bit field distribute: shared types
// assumes bfd_params.svh sits beside it
`default_nettype none

package bfd_pkg;

  // ==========================================================
  // operand widths, zero-extended to 32 bits
  typedef enum logic [1:0] {
    BFD_WORD8,
    BFD_WORD16,
    BFD_WORD32,
    BFD_WORD32_ALT
  } bfd_width_e;

  // ==========================================================
  // control register layout
  typedef struct packed {
    logic [21:0] rsvd;
    bfd_width_e dst_width;
    bfd_width_e src_width;
    logic text_form;
    logic enable_input;
    logic postscan;
    logic prescan;
    logic step_in;
    logic targeted;
  } bfd_ctrl_s;

  // field register layout
  typedef struct packed {
    logic [9:0] rsvd_hi;
    logic [5:0] length;
    logic [2:0] rsvd_mid;
    logic [4:0] destination_bit_position;
    logic [2:0] rsvd_lo;
    logic [4:0] source_bit_position;
  } bfd_field_s;

  // avalon request bundle
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bfd_avreq_s;

endpackage : bfd_pkg

`default_nettype wire

// *** test/bfd_distribute_properties.sv ***
// checker: bus timing and run-output relations of the distribute block
// assumes binding to bfd_distribute, one clock, synchronous reset
`default_nettype none
module bfd_distribute_properties (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic [3:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // lanes
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic step_out, // step out
  input wire logic enable_output, // valid
  input wire logic [31:0] result_word, // result
  input wire logic [31:0] destination_word, // destination
  input wire logic flag_zero, // zero
  input wire logic flag_sign // sign
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic acc = avs_write && !avs_waitrequest;
  wire logic run = acc && avs_address == 4'h7 && avs_writedata[0] && avs_byteenable[0];
  wire logic dwr = acc && avs_address == 4'h4;
  // ==========================================================
  // bus
  property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer after one wait");
  property p_wait_one; !avs_waitrequest |-> $past(avs_read || avs_write) ##1 avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("stray or long answer");
  property p_rd_hold; $changed(avs_readdata) |-> $past(avs_read && avs_waitrequest); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // ==========================================================
  // run outputs move only two edges after an accepted go; destination also one edge after its own write
  property p_step; $changed(step_out) |-> $past(run, 2); endproperty
  a_step: assert property (p_step) else $error("step out moved alone");
  property p_dest; $changed(destination_word) |-> (step_out && $past(run, 2)) || $past(dwr); endproperty
  a_dest: assert property (p_dest) else $error("destination moved");
  property p_en; $changed(enable_output) |-> $past(run, 2); endproperty
  a_en: assert property (p_en) else $error("enable output moved alone");
  property p_res; $changed(result_word) |-> enable_output && $past(run, 2); endproperty
  a_res: assert property (p_res) else $error("result moved");
  property p_flag_q; $changed({flag_zero, flag_sign}) |-> enable_output && $past(run, 2); endproperty
  a_flag_q: assert property (p_flag_q) else $error("flags moved");
  property p_flag_v;
    $past(run, 2) && enable_output |-> flag_zero == (result_word == 32'h0) && flag_sign == result_word[31];
  endproperty
  a_flag_v: assert property (p_flag_v) else $error("flags disagree with result");
endmodule : bfd_distribute_properties

bind bfd_distribute bfd_distribute_properties bfd_distribute_properties_i (.clk_sys(clk_sys), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .step_out(step_out), .enable_output(enable_output), .result_word(result_word),
  .destination_word(destination_word), .flag_zero(flag_zero), .flag_sign(flag_sign));
`default_nettype wire

// *** test/bfd_seq_model.sv ***
// sequencer model: bus master and builder of legal field words
// assumes calls start just after a rising edge
`default_nettype none
module bfd_seq_model (
  input wire logic clk_sys, // clock
  input wire logic avs_waitrequest, // stall
  input wire logic [31:0] avs_readdata, // read data
  output var logic [3:0] avs_address, // address
  output var logic avs_read, // read
  output var logic avs_write, // write
  output var logic [31:0] avs_writedata, // write data
  output var logic [3:0] avs_byteenable // lanes
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hf;
  end
  // ==========================================================
  // one transfer, held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released data must not look like the last value
    avs_writedata <= ~d;
    @(posedge clk_sys);
  endtask : xfer
  // lane mask for the writes that follow; call just after a rising edge
  task automatic lanes(input logic [3:0] b);
    avs_byteenable <= b;
  endtask : lanes
  function automatic int lim(input logic [1:0] w);
    return w == 2'h0 ? 8 : w == 2'h1 ? 16 : 32;
  endfunction : lim
  function automatic logic [31:0] fld(input logic [31:0] r, input logic [1:0] sw, dw);
    fld = 32'h0;
    fld[4:0] = 5'(r[7:0] % lim(sw));
    fld[12:8] = 5'(r[15:8] % lim(dw));
    fld[21:16] = 6'(r[20:16]) + 6'h1;
  endfunction : fld
endmodule : bfd_seq_model
`default_nettype wire

// *** test/testbench.sv ***
// bench: random runs of both variants against a reference model
// assumes the design, its checker and the sequencer model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address, avs_byteenable;
  logic avs_read, avs_write, avs_waitrequest, step_out, enable_output, flag_zero, flag_sign;
  logic [31:0] avs_writedata, avs_readdata, result_word, destination_word;
  logic [31:0] lfsr = 32'h41;
  logic [31:0] m_dst, m_res, q, src, tgt, c, f, r, bm;
  logic [3:0] ln4;
  logic m_step, m_en, m_z, m_s;
  int n_fail = 0;
  int tests_run = 0;
  always #50 clk_sys = ~clk_sys;
  bfd_distribute bfd_distribute_i (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .step_out(step_out),
    .enable_output(enable_output), .result_word(result_word), .destination_word(destination_word),
    .flag_zero(flag_zero), .flag_sign(flag_sign));
  bfd_seq_model bfd_seq_model_i (.clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    repeat (32) lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h8020_0003 : lfsr >> 1;
    return lfsr;
  endfunction : rnd
  function automatic longint unsigned wm(input int w);
    return w == 0 ? 64'hff : w == 1 ? 64'hffff : 64'hffff_ffff;
  endfunction : wm
  function automatic logic [31:0] ins(input logic [31:0] s, b, input int sp, dp, ln, sw, dw, g);
    longint unsigned m, v;
    m = (64'h1 << ln) - 64'h1;
    v = ((s & wm(sw)) >> sp) & m;
    v = (b & ~(m << dp)) | (v << dp);
    // bits past the top are cut, never wrapped
    return 32'(g ? v & wm(dw) : v);
  endfunction : ins
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bfd_seq_model_i.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    bfd_seq_model_i.xfer(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask : rd
  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    {m_dst, m_res, m_step, m_en, m_z, m_s} = '0;
    rd(4'h0, 32'h290, "ctrl");
    rd(4'h2, 32'h1_0000, "field");
    for (int a = 1; a < 16; a++) if (a != 2) rd(4'(a), 32'h0, "reset word");
    $display("test reset done");
  endtask : do_reset
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // main sequence
  initial begin
    do_reset();
    for (int i = 0; i < 40; i++) begin
      if (i == 20) do_reset();
      src = rnd();
      tgt = rnd();
      r = rnd();
      c = rnd() & 32'h3ff;
      if (r[31]) c[3:2] = 2'h0;
      // first two runs fix the control word, targeted then gated; their field word is random like the rest
      if (i < 2) c = 32'h291 + 32'(i);
      if (i < 2) r = i ? 32'h001f_1f00 : 32'h001f_0000;
      f = bfd_seq_model_i.fld(r, c[7:6], c[9:8]);
      // destination preload through random byte lanes; unselected lanes keep their bytes
      ln4 = 4'(rnd());
      bm = {{8{ln4[3]}}, {8{ln4[2]}}, {8{ln4[1]}}, {8{ln4[0]}}};
      f = rnd();
      m_dst = (m_dst & ~bm) | (f & bm);
      bfd_seq_model_i.lanes(ln4);
      wr(4'h4, f);
      bfd_seq_model_i.lanes(4'hf);
      wr(4'h5, rnd());
      wr(4'h0, c);
      wr(4'h1, src);
      wr(4'h2, f);
      wr(4'h3, tgt);
      wr(4'h7, 32'h1);
      if (c[0]) begin
        m_en = c[4] | c[5];
        if (m_en) m_res = ins(src, tgt, f[4:0], f[12:8], f[21:16], c[7:6], 3, 0);
        if (m_en) {m_s, m_z} = {m_res[31], m_res == 32'h0};
      end else begin
        m_step = c[1] & !c[2] & !c[3];
        if (m_step) m_dst = ins(src, m_dst, f[4:0], f[12:8], f[21:16], c[7:6], c[9:8], 1);
      end
      @(negedge clk_sys);
      chk("step_out", 32'(step_out), 32'(m_step));
      chk("enable_output", 32'(enable_output), 32'(m_en));
      chk("result_word", result_word, m_res);
      chk("destination_word", destination_word, m_dst);
      chk("flags", 32'({flag_sign, flag_zero}), 32'({m_s, m_z}));
      @(posedge clk_sys);
      rd(4'h1, src, "source");
      rd(4'h3, tgt, "target");
      rd(4'h5, m_res, "result reg");
      rd(4'h6, 32'({m_s, m_z, m_en, m_step}), "status");
    end
    $display("test random runs done");
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
